// file: hdl/fsmc_regs.svh
// register offsets, field positions, reset values, clock rate and booster frequencies
`ifndef FSMC_REGS_SVH
`define FSMC_REGS_SVH
`define FSMC_CTRL_OFF 8'h00
`define FSMC_CFG_OFF 8'h04
`define FSMC_STAT_OFF 8'h08
`define FSMC_INTS_OFF 8'h0c
`define FSMC_INTM_OFF 8'h10
`define FSMC_MODE_RST 3'h0
`define FSMC_STAT_FSO 0
`define FSMC_STAT_ERR 1
`define FSMC_STAT_SAFE 2
`define FSMC_STAT_SA 3
`define FSMC_RESP_OK 2'h0
`define FSMC_RESP_ERR 2'h2
// clock rate in kHz, booster frequencies in units of 0.1 kHz
`define FSMC_CLK_KHZ 100000
`define FSMC_F0 2000
`define FSMC_F1 2941
`define FSMC_F2 4167
`define FSMC_F3 5000
`define FSMC_F4 6250
`define FSMC_F5 7143
`define FSMC_F6 8330
`define FSMC_F7 10000
`endif

// file: hdl/fsmc_pkg.sv
// types shared by the fail-safe mode controller
package fsmc_pkg;
   typedef struct packed {
      logic [2:0] freq;   // safe_boost_freq_select
      logic       pinsel; // pin_function_select
      logic [2:0] mode;   // safe_mode_select
   } fsmc_ctrl_t;
   typedef struct packed {
      logic [9:0] cfg;
      fsmc_ctrl_t ctrl;
   } fsmc_image_t;
   typedef enum logic [1:0] {FSMC_INIT, FSMC_NORMAL, FSMC_SAFE} fsmc_state_t;
   typedef struct packed {
      logic err;
      logic exit_ev;
      logic entry;
   } fsmc_irq_t;
endpackage

// file: hdl/fsmc_pwm.sv
// internal booster pwm source, 50% duty
`timescale 1ns/1ns
`default_nettype none
`include "fsmc_regs.svh"
module fsmc_pwm (
   input  wire logic       clock_i,
   input  wire logic       srst_i,
   input  wire logic       en_i,
   input  wire logic [2:0] freq_i,
   output var  logic       pwm_o
);
   logic [8:0] cnt;

   // half period in clock cycles, rounded down
   function automatic logic [8:0] f_half(input logic [2:0] f);
      int unsigned d;
      unique case (f)
         3'h0: d = `FSMC_F0;
         3'h1: d = `FSMC_F1;
         3'h2: d = `FSMC_F2;
         3'h3: d = `FSMC_F3;
         3'h4: d = `FSMC_F4;
         3'h5: d = `FSMC_F5;
         3'h6: d = `FSMC_F6;
         3'h7: d = `FSMC_F7;
      endcase
      return 9'((`FSMC_CLK_KHZ * 10) / (2 * d));
   endfunction

   // equal high and low halves give the 50% duty
   always_ff @(posedge clock_i)
   begin
      if (srst_i || !en_i)
      begin
         cnt   <= 9'h0;
         pwm_o <= 1'b0;
      end
      else if (cnt >= f_half(freq_i) - 9'h1)
      begin
         cnt   <= 9'h0;
         pwm_o <= ~pwm_o;
      end
      else
         cnt <= cnt + 9'h1;
   end

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);

   property p_pwm_half;
      en_i && $past(en_i) && $changed(pwm_o) |-> $past(cnt) == f_half($past(freq_i)) - 9'h1;
   endproperty
   a_pwm_half: assert property (p_pwm_half)
      else $error("pwm toggled off the half period");
   c_pwm_run: cover property (en_i && $rose(pwm_o));
endmodule // fsmc_pwm
`default_nettype wire

// file: hdl/fsmc_ctrl.sv
// fail-safe and stand-alone mode controller with axi4-lite registers
//
// Chosen here: the AXI4-Lite register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "fsmc_regs.svh"
module fsmc_ctrl (
   input  wire logic                 clock_i,
   input  wire logic                 srst_i,
   input  wire logic                 axi_awvalid_i,
   output var  logic                 axi_awready_o,
   input  wire logic [7:0]           axi_awaddr_i,
   input  wire logic                 axi_wvalid_i,
   output var  logic                 axi_wready_o,
   input  wire logic [31:0]          axi_wdata_i,
   input  wire logic [3:0]           axi_wstrb_i,
   output var  logic                 axi_bvalid_o,
   input  wire logic                 axi_bready_i,
   output var  logic [1:0]           axi_bresp_o,
   input  wire logic                 axi_arvalid_i,
   output var  logic                 axi_arready_o,
   input  wire logic [7:0]           axi_araddr_i,
   output var  logic                 axi_rvalid_o,
   input  wire logic                 axi_rready_i,
   output var  logic [31:0]          axi_rdata_o,
   output var  logic [1:0]           axi_rresp_o,
   input  wire fsmc_pkg::fsmc_image_t otp_image_i,
   input  wire logic                 otp_locked_i,
   input  wire logic                 safe_entry_pin_i,
   input  wire logic                 frame_err_i,
   output var  fsmc_pkg::fsmc_image_t ctrl_o,
   output var  logic                 safe_active_o,
   output var  logic                 standalone_o,
   output var  logic                 boost_src_int_o,
   output var  logic                 boost_pwm_o,
   output var  logic                 irq_o
);
   // ==========================================================
   // decode helpers
   function automatic logic f_hit(input logic [7:0] a, input logic [7:0] off);
      return a[7:2] == off[7:2];
   endfunction

   // modes whose safe state blocks serial writes
   function automatic logic f_locked(input logic [2:0] m);
      return !m[0] && (m[2:1] != 2'b00);
   endfunction

   // modes whose pin may enter safe mode
   function automatic logic f_pin_mode(input logic [2:0] m);
      return (m >= 3'h2) && (m != 3'h6);
   endfunction

   // modes that start from one-time memory contents
   function automatic logic f_otp_load(input logic [2:0] m);
      return (m == 3'h1) || m[2];
   endfunction

   function automatic logic [31:0] f_merge(input logic [31:0] o,
                                           input logic [31:0] n,
                                           input logic [3:0]  s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++)
         if (s[i])
            r[8*i +: 8] = n[8*i +: 8];
      return r;
   endfunction

   // ==========================================================
   // safe entry pin synchroniser
   logic [1:0] pin_sync;
   logic       pin_prev;

   // idle level is high, so reset to one avoids a false edge
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         pin_sync <= 2'b11;
         pin_prev <= 1'b1;
      end
      else
      begin
         pin_sync <= {pin_sync[0], safe_entry_pin_i};
         pin_prev <= pin_sync[1];
      end
   end

   logic pin_fall;
   logic pin_rise;
   assign pin_fall = pin_prev & ~pin_sync[1];
   assign pin_rise = ~pin_prev & pin_sync[1];

   // ==========================================================
   // bus handshakes
   fsmc_pkg::fsmc_state_t state;
   fsmc_pkg::fsmc_state_t next_state;
   logic                  wr_fire;
   logic                  rd_fire;
   logic                  blocked;
   logic                  wr_ctrl;
   logic                  wr_cfg;
   logic [31:0]           wr_val;
   logic [2:0]            boot_mode;
   logic                  enter_pin;
   logic                  exit_pin;
   logic                  exit_wr;

   assign wr_fire = axi_awready_o & axi_awvalid_i;
   assign rd_fire = axi_arready_o & axi_arvalid_i;
   assign blocked = (state == fsmc_pkg::FSMC_SAFE) && f_locked(ctrl_o.ctrl.mode);
   // a locked control or cfg write is answered okay but changes nothing
   assign wr_ctrl = wr_fire && f_hit(axi_awaddr_i, `FSMC_CTRL_OFF) && !blocked;
   assign wr_cfg  = wr_fire && f_hit(axi_awaddr_i, `FSMC_CFG_OFF) && !blocked;
   assign wr_val  = f_merge({25'h0, ctrl_o.ctrl}, axi_wdata_i, axi_wstrb_i);

   // slave waits for address and data together, then takes both
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         axi_awready_o <= 1'b0;
         axi_wready_o  <= 1'b0;
      end
      else
      begin
         axi_awready_o <= !axi_awready_o && axi_awvalid_i && axi_wvalid_i && !axi_bvalid_o;
         axi_wready_o  <= !axi_awready_o && axi_awvalid_i && axi_wvalid_i && !axi_bvalid_o;
      end
   end

   // write response
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         axi_bvalid_o <= 1'b0;
         axi_bresp_o  <= `FSMC_RESP_OK;
      end
      else if (wr_fire)
      begin
         axi_bvalid_o <= 1'b1;
         axi_bresp_o  <= (axi_awaddr_i > `FSMC_INTM_OFF + 8'h3) ? `FSMC_RESP_ERR : `FSMC_RESP_OK;
      end
      else if (axi_bready_i)
         axi_bvalid_o <= 1'b0;
   end

   // ==========================================================
   // mode state machine
   assign boot_mode = otp_locked_i ? otp_image_i.ctrl.mode : `FSMC_MODE_RST;
   assign enter_pin = pin_fall && f_pin_mode(ctrl_o.ctrl.mode) && !ctrl_o.ctrl.pinsel
                      && otp_locked_i;
   assign exit_pin  = pin_rise && !standalone_o && !ctrl_o.ctrl.pinsel;
   assign exit_wr   = wr_ctrl && ((wr_val[2:0] <= 3'h1) || wr_val[3]);

   always_comb
   begin
      next_state = state;
      unique case (state)
         fsmc_pkg::FSMC_INIT:
            next_state = (boot_mode[2:1] == 2'b11) ? fsmc_pkg::FSMC_SAFE
                                                   : fsmc_pkg::FSMC_NORMAL;
         fsmc_pkg::FSMC_NORMAL:
            if (enter_pin)
               next_state = fsmc_pkg::FSMC_SAFE;
         fsmc_pkg::FSMC_SAFE:
            if (exit_pin || exit_wr)
               next_state = fsmc_pkg::FSMC_NORMAL;
      endcase
   end

   logic entry_ev;
   logic exit_ev;
   assign entry_ev = (next_state == fsmc_pkg::FSMC_SAFE) && (state != fsmc_pkg::FSMC_SAFE);
   assign exit_ev  = (next_state != fsmc_pkg::FSMC_SAFE) && (state == fsmc_pkg::FSMC_SAFE);

   // state and the pwm source select move together
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         state           <= fsmc_pkg::FSMC_INIT;
         safe_active_o   <= 1'b0;
         boost_src_int_o <= 1'b0;
         standalone_o    <= 1'b0;
      end
      else
      begin
         state           <= next_state;
         safe_active_o   <= next_state == fsmc_pkg::FSMC_SAFE;
         boost_src_int_o <= next_state == fsmc_pkg::FSMC_SAFE;
         if (state == fsmc_pkg::FSMC_INIT)
            standalone_o <= next_state == fsmc_pkg::FSMC_SAFE;
         else if (exit_ev)
            standalone_o <= 1'b0;
      end
   end

   // ==========================================================
   // control registers
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
         ctrl_o <= '0;
      else if (state == fsmc_pkg::FSMC_INIT)
      begin
         ctrl_o <= f_otp_load(boot_mode) ? otp_image_i : '0;
         ctrl_o.ctrl.mode <= boot_mode;
      end
      else if (enter_pin && state == fsmc_pkg::FSMC_NORMAL)
      begin
         // mode field keeps its live value across the reload
         ctrl_o <= otp_image_i;
         ctrl_o.ctrl.mode <= ctrl_o.ctrl.mode;
      end
      else if (wr_ctrl)
         ctrl_o.ctrl <= wr_val[6:0];
      else if (wr_cfg)
         ctrl_o.cfg <= axi_wdata_i[9:0];
   end

   // ==========================================================
   // status flags, set wins over clear-on-read
   logic fso_flag;
   logic serial_error_flag;
   logic rd_stat;
   assign rd_stat = rd_fire && f_hit(axi_araddr_i, `FSMC_STAT_OFF) && !blocked;

   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         fso_flag          <= 1'b0;
         serial_error_flag <= 1'b0;
      end
      else
      begin
         fso_flag          <= entry_ev || (fso_flag && !rd_stat);
         serial_error_flag <= frame_err_i || (serial_error_flag && !rd_stat);
      end
   end

   // ==========================================================
   // interrupt status and mask
   fsmc_pkg::fsmc_irq_t int_stat;
   fsmc_pkg::fsmc_irq_t int_mask;
   fsmc_pkg::fsmc_irq_t next_int;
   logic [2:0]          w1c;

   assign w1c      = (wr_fire && f_hit(axi_awaddr_i, `FSMC_INTS_OFF) && axi_wstrb_i[0])
                     ? axi_wdata_i[2:0] : 3'h0;
   assign next_int = (int_stat & ~w1c) | {frame_err_i, exit_ev, entry_ev};

   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         int_stat <= '0;
         int_mask <= '0;
         irq_o    <= 1'b0;
      end
      else
      begin
         int_stat <= next_int;
         irq_o    <= |(next_int & int_mask);
         if (wr_fire && f_hit(axi_awaddr_i, `FSMC_INTM_OFF) && axi_wstrb_i[0])
            int_mask <= axi_wdata_i[2:0];
      end
   end

   // ==========================================================
   // read path, data and response one cycle after arready
   always_ff @(posedge clock_i)
   begin
      if (srst_i)
      begin
         axi_arready_o <= 1'b0;
         axi_rvalid_o  <= 1'b0;
         axi_rdata_o   <= 32'h0;
         axi_rresp_o   <= `FSMC_RESP_OK;
      end
      else
      begin
         axi_arready_o <= !axi_arready_o && axi_arvalid_i && !axi_rvalid_o;
         if (rd_fire)
         begin
            axi_rvalid_o <= 1'b1;
            axi_rresp_o  <= `FSMC_RESP_OK;
            axi_rdata_o  <= 32'h0;
            if (f_hit(axi_araddr_i, `FSMC_CTRL_OFF))
               axi_rdata_o[6:0] <= ctrl_o.ctrl;
            else if (f_hit(axi_araddr_i, `FSMC_CFG_OFF))
               axi_rdata_o[9:0] <= ctrl_o.cfg;
            else if (f_hit(axi_araddr_i, `FSMC_STAT_OFF))
               axi_rdata_o[3:0] <= {standalone_o, safe_active_o, serial_error_flag, fso_flag};
            else if (f_hit(axi_araddr_i, `FSMC_INTS_OFF))
               axi_rdata_o[2:0] <= int_stat;
            else if (f_hit(axi_araddr_i, `FSMC_INTM_OFF))
               axi_rdata_o[2:0] <= int_mask;
            else
               axi_rresp_o <= `FSMC_RESP_ERR;
         end
         else if (axi_rready_i)
            axi_rvalid_o <= 1'b0;
      end
   end

   // ==========================================================
   // internal booster pwm
   fsmc_pwm u_pwm (
      .clock_i (clock_i),
      .srst_i  (srst_i),
      .en_i    (boost_src_int_o),
      .freq_i  (ctrl_o.ctrl.freq),
      .pwm_o   (boost_pwm_o)
   );

   // ==========================================================
   // checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (srst_i);

   // sampled reset guards the release edge, where the disable has already dropped
   property p_zero_load;
      !srst_i && state == fsmc_pkg::FSMC_INIT && !f_otp_load(boot_mode) |=> ctrl_o.cfg == 10'h0;
   endproperty
   a_zero_load: assert property (p_zero_load)
      else $error("control not cleared after reset");

   property p_otp_load;
      !srst_i && state == fsmc_pkg::FSMC_INIT && f_otp_load(boot_mode)
         |=> ctrl_o.cfg == $past(otp_image_i.cfg);
   endproperty
   a_otp_load: assert property (p_otp_load)
      else $error("control not loaded from memory");

   property p_no_entry;
      safe_active_o |-> ctrl_o.ctrl.mode >= 3'h2 || $past(exit_wr);
   endproperty
   a_no_entry: assert property (p_no_entry)
      else $error("safe mode in a mode that forbids it");

   property p_pin_entry;
      state == fsmc_pkg::FSMC_NORMAL && enter_pin
         |=> safe_active_o ##0 ctrl_o.cfg == $past(otp_image_i.cfg);
   endproperty
   a_pin_entry: assert property (p_pin_entry)
      else $error("pin entry missing or no reload");

   property p_startup;
      !srst_i && state == fsmc_pkg::FSMC_INIT && boot_mode[2:1] == 2'b11
         |=> safe_active_o && standalone_o;
   endproperty
   a_startup: assert property (p_startup)
      else $error("no stand-alone entry after reset");

   property p_lock;
      blocked && wr_fire |=> $stable(ctrl_o);
   endproperty
   a_lock: assert property (p_lock)
      else $error("write taken while locked");

   property p_err;
      frame_err_i |=> serial_error_flag ##0 int_stat.err;
   endproperty
   a_err: assert property (p_err)
      else $error("serial error not flagged");

   property p_exit_wr;
      safe_active_o && exit_wr |=> !safe_active_o ##1 !boost_src_int_o;
   endproperty
   a_exit_wr: assert property (p_exit_wr)
      else $error("safe mode not left on write");

   property p_src;
      $rose(safe_active_o) |-> boost_src_int_o && fso_flag;
   endproperty
   a_src: assert property (p_src)
      else $error("entry without internal source or flag");

   property p_lock_bit;
      $rose(safe_active_o) |-> $past(otp_locked_i);
   endproperty
   a_lock_bit: assert property (p_lock_bit)
      else $error("entry without memory lock");

   c_pin_enter: cover property (enter_pin ##1 safe_active_o);
   c_pin_exit: cover property (safe_active_o && exit_pin);
   c_wr_exit: cover property (safe_active_o && exit_wr);
   c_locked_wr: cover property (blocked && wr_fire);
endmodule // fsmc_ctrl
`default_nettype wire

// file: testbench/fsmc_far_model.sv
// far-side model: one-time memory image, safe entry pin and bad serial frames
`timescale 1ns/1ns
`default_nettype none
module fsmc_far_model (
   input  wire logic                  clock_i,
   output var  fsmc_pkg::fsmc_image_t otp_image_o,
   output var  logic                  otp_locked_o,
   output var  logic                  pin_o,
   output var  logic                  frame_err_o
);
   // ==========================================================
   // idle state: blank unlocked memory, pin pulled high
   initial
   begin
      otp_image_o = '0;
      otp_locked_o = 1'b0;
      pin_o = 1'b1;
      frame_err_o = 1'b0;
   end

   // ==========================================================
   // memory image is only changed ahead of a reset, never mid-run
   task automatic set_otp(input fsmc_pkg::fsmc_image_t img, input logic lck);
      @(posedge clock_i);
      otp_image_o <= img;
      otp_locked_o <= lck;
   endtask

   // pin level; the design synchronises it, so edge timing is free
   task automatic set_pin(input logic v);
      @(posedge clock_i);
      pin_o <= v;
   endtask

   // one invalid frame reported as a single-cycle pulse
   task automatic bad_frame();
      @(posedge clock_i);
      frame_err_o <= 1'b1;
      @(posedge clock_i);
      frame_err_o <= 1'b0;
   endtask
endmodule // fsmc_far_model
`default_nettype wire

// file: testbench/tb_top.sv
// self-checking bench for the fail-safe mode controller
`timescale 1ns/1ns
`default_nettype none
`include "fsmc_regs.svh"
module tb_top;
   // ==========================================================
   // signals
   logic                  clock_i;
   logic                  srst_i;
   logic                  awvalid, wvalid, bready, arvalid, rready;
   logic [7:0]            awaddr, araddr;
   logic [31:0]           wdata, rd;
   logic [3:0]            wstrb;
   logic                  awready, wready, bvalid, arready, rvalid;
   logic [1:0]            bresp, rresp, br, rr;
   logic [31:0]           rdata;
   fsmc_pkg::fsmc_image_t otp_image, ctrl;
   logic                  otp_locked, pin, frame_err;
   logic                  safe, alone, src_int, pwm, irq;
   int                    mismatches, checked, n;

   // ==========================================================
   // instances
   fsmc_ctrl fsmc_ctrl_inst (.clock_i(clock_i), .srst_i(srst_i),
      .axi_awvalid_i(awvalid), .axi_awready_o(awready), .axi_awaddr_i(awaddr),
      .axi_wvalid_i(wvalid), .axi_wready_o(wready), .axi_wdata_i(wdata),
      .axi_wstrb_i(wstrb), .axi_bvalid_o(bvalid), .axi_bready_i(bready),
      .axi_bresp_o(bresp), .axi_arvalid_i(arvalid), .axi_arready_o(arready),
      .axi_araddr_i(araddr), .axi_rvalid_o(rvalid), .axi_rready_i(rready),
      .axi_rdata_o(rdata), .axi_rresp_o(rresp), .otp_image_i(otp_image),
      .otp_locked_i(otp_locked), .safe_entry_pin_i(pin), .frame_err_i(frame_err),
      .ctrl_o(ctrl), .safe_active_o(safe), .standalone_o(alone),
      .boost_src_int_o(src_int), .boost_pwm_o(pwm), .irq_o(irq));
   fsmc_far_model fsmc_far_model_inst (.clock_i(clock_i), .otp_image_o(otp_image),
      .otp_locked_o(otp_locked), .pin_o(pin), .frame_err_o(frame_err));

   // ==========================================================
   // clock and watchdog; a hang counts as a mismatch
   initial
   begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end
   initial
   begin
      #500000;
      mismatches++;
      end_sim();
   end

   // ==========================================================
   // helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // write: address and data offered together, each held until taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_i);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      awaddr <= a;
      wdata <= d;
      bready <= 1'b1;
      @(posedge clock_i);
      // each channel is released at the edge where its own ready is seen
      while (awvalid || wvalid)
      begin
         if (awready === 1'b1)
            awvalid <= 1'b0;
         if (wready === 1'b1)
            wvalid <= 1'b0;
         @(posedge clock_i);
      end
      while (bvalid !== 1'b1) @(posedge clock_i);
      br = bresp;
      bready <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge clock_i);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      @(posedge clock_i);
      while (arready !== 1'b1) @(posedge clock_i);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge clock_i);
      rd = rdata;
      rr = rresp;
      rready <= 1'b0;
   endtask
   // memory image: recognisable cfg, top frequency code, pin select 0
   function automatic fsmc_pkg::fsmc_image_t img(input logic [2:0] m);
      return {10'h2a5, 3'h7, 1'b0, m};
   endfunction
   // reset held two cycles with the image already steady
   task automatic rst(input logic [2:0] m, input logic lck);
      fsmc_far_model_inst.set_otp(img(m), lck);
      srst_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      srst_i <= 1'b0;
      repeat (3) @(posedge clock_i);
   endtask
   // pin change, then enough cycles for sync and state update
   task automatic pin_to(input logic v);
      fsmc_far_model_inst.set_pin(v);
      repeat (8) @(posedge clock_i);
   endtask

   // ==========================================================
   // tests
   initial
   begin
      srst_i = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'hf;
      mismatches = 0;
      checked = 0;
      // unlocked memory: mode forced to 000, pin ignored
      rst(3'h5, 1'b0);
      check(ctrl, 32'h0);
      wr(`FSMC_CTRL_OFF, 32'h73);
      pin_to(1'b0);
      check(safe, 1'b0);
      pin_to(1'b1);
      // 000 and 001 never enter on the pin
      rst(3'h0, 1'b1);
      check(ctrl, 32'h0);
      pin_to(1'b0);
      check(safe, 1'b0);
      pin_to(1'b1);
      rst(3'h1, 1'b1);
      check(ctrl, img(3'h1));
      pin_to(1'b0);
      check(safe, 1'b0);
      pin_to(1'b1);
      // 011: zeros at reset, pin entry reloads, writes accepted
      rst(3'h3, 1'b1);
      check(ctrl, 32'h3);
      rdr(`FSMC_CTRL_OFF);
      check(rd, 32'h3);
      wr(`FSMC_INTM_OFF, 32'h1);
      pin_to(1'b0);
      check(safe, 1'b1);
      check(ctrl, img(3'h3));
      check(src_int, 1'b1);
      check(irq, 1'b1);
      rdr(`FSMC_STAT_OFF);
      check(rd[0], 1'b1);
      rdr(`FSMC_STAT_OFF);
      check(rd[0], 1'b0);
      wr(`FSMC_INTS_OFF, 32'h1);
      check(irq, 1'b0);
      wr(`FSMC_CFG_OFF, 32'h155);
      rdr(`FSMC_CFG_OFF);
      check(rd, 32'h155);
      wr(`FSMC_CTRL_OFF, 32'h7b);
      check(safe, 1'b0);
      check(src_int, 1'b0);
      wr(`FSMC_CTRL_OFF, 32'h73);
      pin_to(1'b1);
      pin_to(1'b0);
      check(safe, 1'b1);
      wr(`FSMC_CTRL_OFF, 32'h70);
      check(safe, 1'b0);
      wr(`FSMC_CTRL_OFF, 32'h73);
      pin_to(1'b1);
      pin_to(1'b0);
      check(safe, 1'b1);
      pin_to(1'b1);
      check(safe, 1'b0);
      // 100: memory at reset, locked while in safe mode
      rst(3'h4, 1'b1);
      check(ctrl, img(3'h4));
      pin_to(1'b0);
      check(safe, 1'b1);
      wr(`FSMC_CTRL_OFF, 32'h0);
      check(ctrl, img(3'h4));
      check(safe, 1'b1);
      fsmc_far_model_inst.bad_frame();
      rdr(`FSMC_STAT_OFF);
      check(rd[1:0], 2'h3);
      rdr(`FSMC_STAT_OFF);
      check(rd[1:0], 2'h3);
      rdr(8'h20);
      check({30'h0, rr}, 32'h2);
      check(rd, 32'h0);
      wr(8'h20, 32'h1);
      check(br, 2'h2);
      pin_to(1'b1);
      check(safe, 1'b0);
      // 010: zeros at reset, pin entry reloads, then writes are ignored
      rst(3'h2, 1'b1);
      check(ctrl, 32'h2);
      pin_to(1'b0);
      check(safe, 1'b1);
      check(ctrl, img(3'h2));
      wr(`FSMC_CFG_OFF, 32'h155);
      rdr(`FSMC_CFG_OFF);
      check(rd, 32'h2a5);
      pin_to(1'b1);
      check(safe, 1'b0);
      // 101: memory at reset, left by writing mode 000 with the pin select set
      rst(3'h5, 1'b1);
      check(ctrl, img(3'h5));
      pin_to(1'b0);
      check(safe, 1'b1);
      wr(`FSMC_CTRL_OFF, 32'h78);
      check(safe, 1'b0);
      pin_to(1'b1);
      // 110: stand-alone from reset, pwm at the top frequency with 50% duty
      rst(3'h6, 1'b1);
      check({safe, alone, src_int}, 3'h7);
      check(ctrl, img(3'h6));
      while (pwm !== 1'b0) @(posedge clock_i);
      while (pwm !== 1'b1) @(posedge clock_i);
      n = 0;
      while (pwm === 1'b1)
      begin
         @(posedge clock_i);
         n++;
      end
      check(n, 32'd50);
      n = 0;
      while (pwm === 1'b0)
      begin
         @(posedge clock_i);
         n++;
      end
      check(n, 32'd50);
      pin_to(1'b0);
      pin_to(1'b1);
      wr(`FSMC_CTRL_OFF, 32'h70);
      check(safe, 1'b1);
      // 111: stand-alone left by writing mode 001
      rst(3'h7, 1'b1);
      check(safe, 1'b1);
      wr(`FSMC_CTRL_OFF, 32'h71);
      check(safe, 1'b0);
      check(ctrl.ctrl.mode, 3'h1);
      end_sim();
   end
endmodule // tb_top
`default_nettype wire
